// ---- logic/hses_top.sv ----
// strap capture, eeprom pin select and downstream port power control
// -----------------------------------------------------------------------
// Notes on behaviour
// - a high power-source strap means bus-powered, low means self-powered.
// - the power-source strap is an active-high bus-power indicator.
// - a high eeprom-disable strap turns the eeprom interface fully off.
// - with eeprom off the clock pin stays idle and is left unconnected.
// - a low eeprom-disable strap makes the two pins eeprom clock and data.
// - with eeprom on the clock pin is a three-state serial clock output.
// - with eeprom on the data pin is a two-way serial data line.
// - with eeprom off the data pin is read as the gang-select strap.
// - ganged mode switches all ports together; any fault powers all off.
// - per-port mode powers and trips each port on its own.
// - overcurrent inputs are active low and noise filtered before use.
// -----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module hses_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration straps
    input wire logic power_source_strap,
    input wire logic eeprom_disable_strap,
    // eeprom clock pin
    output logic eeprom_serial_clock_o,
    output logic eeprom_serial_clock_oe_n,
    // eeprom data or gang strap pin
    input wire logic eeprom_data_or_gang_strap_i,
    output logic eeprom_data_or_gang_strap_o,
    output logic eeprom_data_or_gang_strap_oe_n,
    // downstream port pins
    input wire logic [3:0] port_overcurrent_n,
    output logic [3:0] port_power_enable_n,
    // eeprom engine side
    input wire logic ee_clk_level,
    input wire logic ee_clk_drive,
    input wire logic ee_data_level,
    input wire logic ee_data_drive,
    output logic ee_data_in,
    // hub engine side
    input wire logic [3:0] port_power_req,
    output logic [3:0] port_fault,
    output logic cfg_valid,
    output logic bus_powered,
    output logic eeprom_enabled,
    output logic gang_mode
);
    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    wire logic [6:0] pins_raw = {port_overcurrent_n,
        eeprom_data_or_gang_strap_i, eeprom_disable_strap,
        power_source_strap};
    wire logic s_pwr = sync2_q[0];
    wire logic s_eedis = sync2_q[1];
    wire logic s_data = sync2_q[2];
    wire logic [3:0] s_oc_n = sync2_q[6:3];

    // two stages before any logic looks at a pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 7'h7f;
            sync2_q <= 7'h7f;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    // -------------------------------------------------------------------
    // strap capture sequence
    // -------------------------------------------------------------------
    hses_pkg::hses_state_e st_q;
    hses_pkg::hses_state_e st_d;
    logic [hses_pkg::SETTLE_W-1:0] settle_q;
    logic [hses_pkg::SETTLE_W-1:0] settle_d;
    logic bus_pwr_q;
    logic ee_en_q;
    logic gang_q;
    wire logic in_settle = st_q == hses_pkg::HSES_ST_SETTLE;
    wire logic in_capture = st_q == hses_pkg::HSES_ST_CAPTURE;
    wire logic run = st_q == hses_pkg::HSES_ST_RUN;

    // wait for the synchronisers to fill, capture once, then hold
    always_comb begin
        st_d = st_q;
        settle_d = settle_q;
        case (st_q)
            hses_pkg::HSES_ST_SETTLE: begin
                settle_d = settle_q + 1'b1;
                if (settle_q == hses_pkg::SETTLE_LAST) begin
                    st_d = hses_pkg::HSES_ST_CAPTURE;
                end
            end
            hses_pkg::HSES_ST_CAPTURE: begin
                st_d = hses_pkg::HSES_ST_RUN;
            end
            hses_pkg::HSES_ST_RUN: begin
                st_d = hses_pkg::HSES_ST_RUN;
            end
            default: begin
                st_d = hses_pkg::HSES_ST_SETTLE;
                settle_d = '0;
            end
        endcase
    end

    // state and captured configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= hses_pkg::HSES_ST_SETTLE;
            settle_q <= '0;
            bus_pwr_q <= hses_pkg::RST_LOW;
            ee_en_q <= hses_pkg::RST_LOW;
            gang_q <= hses_pkg::RST_LOW;
        end else begin
            st_q <= st_d;
            settle_q <= settle_d;
            if (in_capture) begin
                bus_pwr_q <= s_pwr;
                ee_en_q <= !s_eedis;
                gang_q <= s_eedis && s_data;
            end
        end
    end

    // -------------------------------------------------------------------
    // overcurrent filtering
    // -------------------------------------------------------------------
    hses_oc_if ocif ();
    assign ocif.raw_n = s_oc_n;

    hses_oc_filter u_filter (
        .clk (clk),
        .rst_n (rst_n),
        .ocif (ocif.filt)
    );

    // -------------------------------------------------------------------
    // port power selection
    // -------------------------------------------------------------------
    logic [3:0] trip_q;
    logic [3:0] pwr_n_q;
    wire logic [3:0] req_eff = gang_q ? {4{port_power_req[0]}}
                                      : port_power_req;
    wire logic [3:0] fault_eff = gang_q ? {4{|ocif.fault}}
                                        : ocif.fault;
    wire logic [3:0] trip_d = fault_eff | (trip_q & req_eff);
    wire logic [3:0] pwr_n_d = ~({4{run}} & req_eff & ~trip_d);

    // a trip holds until the port's request drops; a new fault wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_q <= 4'h0;
            pwr_n_q <= {4{hses_pkg::RST_PWR_N}};
        end else begin
            trip_q <= trip_d;
            pwr_n_q <= pwr_n_d;
        end
    end

    // -------------------------------------------------------------------
    // eeprom pin drive
    // -------------------------------------------------------------------
    logic clk_o_q;
    logic clk_oe_n_q;
    logic dat_o_q;
    logic dat_oe_n_q;
    logic dat_in_q;
    wire logic ee_live = run && ee_en_q;

    // pins stay released unless the interface is live
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_o_q <= hses_pkg::RST_LOW;
            clk_oe_n_q <= hses_pkg::RST_OE_N;
            dat_o_q <= hses_pkg::RST_LOW;
            dat_oe_n_q <= hses_pkg::RST_OE_N;
            dat_in_q <= hses_pkg::RST_LOW;
        end else begin
            clk_o_q <= ee_live && ee_clk_level;
            clk_oe_n_q <= !(ee_live && ee_clk_drive);
            dat_o_q <= ee_live && ee_data_level;
            dat_oe_n_q <= !(ee_live && ee_data_drive);
            dat_in_q <= ee_live && s_data;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign eeprom_serial_clock_o = clk_o_q;
    assign eeprom_serial_clock_oe_n = clk_oe_n_q;
    assign eeprom_data_or_gang_strap_o = dat_o_q;
    assign eeprom_data_or_gang_strap_oe_n = dat_oe_n_q;
    assign ee_data_in = dat_in_q;
    assign port_power_enable_n = pwr_n_q;
    assign port_fault = trip_q;
    assign cfg_valid = run;
    assign bus_powered = bus_pwr_q;
    assign eeprom_enabled = ee_en_q;
    assign gang_mode = gang_q;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_capture;
        in_capture ##1 run;
    endsequence

    sequence seq_gang_fault;
        gang_q && |ocif.fault;
    endsequence

    a_capture_bus_power: assert property (
        in_capture |=> bus_powered == $past(s_pwr))
        else $error("bus power not taken from strap");
    a_config_held: assert property (
        seq_capture |=> ##1 ($stable(bus_pwr_q) && $stable(ee_en_q)
            && $stable(gang_q) && run))
        else $error("configuration changed after capture");
    a_off_clock_idle: assert property (
        (run && !ee_en_q) |=> eeprom_serial_clock_oe_n
            && !eeprom_serial_clock_o)
        else $error("eeprom clock driven while disabled");
    a_on_clock_drive: assert property (
        (run && ee_en_q && ee_clk_drive) |=> !eeprom_serial_clock_oe_n
            && eeprom_serial_clock_o == $past(ee_clk_level))
        else $error("eeprom clock not driven");
    a_data_two_way: assert property (
        (run && ee_en_q) |=> eeprom_data_or_gang_strap_oe_n
            == !$past(ee_data_drive))
        else $error("eeprom data direction wrong");
    a_gang_strap_read: assert property (
        in_capture && s_eedis |=> gang_mode == $past(s_data)
            && eeprom_data_or_gang_strap_oe_n)
        else $error("gang strap not read");
    a_gang_fault_off: assert property (
        seq_gang_fault |=> port_power_enable_n == 4'hf)
        else $error("ganged fault left a port powered");
    a_port_own_trip: assert property (
        (run && !gang_q && ocif.fault == 4'h1 && port_power_req[2]
            && !trip_q[2]) |=> !port_power_enable_n[2]
            && port_power_enable_n[0])
        else $error("per-port fault spread to another port");
    a_filter_steady: assert property (
        $rose(ocif.fault[0]) |-> $past(s_oc_n[0]) == 1'b0)
        else $error("fault rose without a low overcurrent sample");
endmodule
`default_nettype wire

// ---- logic/hses_pkg.sv ----
// constants and types shared by the hub strap and eeprom pin-select logic
`default_nettype none
package hses_pkg;
    // -------------------------------------------------------------------
    // sizes and timing
    // -------------------------------------------------------------------
    localparam int NPORTS = 4;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int OC_FILTER_NS = 1000;
    localparam int OC_FILTER_CYCLES =
        (OC_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int OC_CNT_W = 8;
    localparam logic [OC_CNT_W-1:0] OC_CNT_LAST =
        OC_CNT_W'(OC_FILTER_CYCLES - 1);
    localparam int STRAP_SETTLE_CYCLES = 4;
    localparam int SETTLE_W = 3;
    localparam logic [SETTLE_W-1:0] SETTLE_LAST =
        SETTLE_W'(STRAP_SETTLE_CYCLES - 1);

    // -------------------------------------------------------------------
    // values after reset
    // -------------------------------------------------------------------
    localparam logic RST_OE_N = 1'b1;
    localparam logic RST_PWR_N = 1'b1;
    localparam logic RST_LOW = 1'b0;

    // -------------------------------------------------------------------
    // strap capture sequence
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        HSES_ST_SETTLE = 3'b001,
        HSES_ST_CAPTURE = 3'b010,
        HSES_ST_RUN = 3'b100
    } hses_state_e;
endpackage
`default_nettype wire

// ---- logic/hses_oc_if.sv ----
// overcurrent samples toward the filter and filtered faults back
`timescale 1ns/100ps
`default_nettype none
interface hses_oc_if;
    logic [3:0] raw_n;
    logic [3:0] fault;
    modport filt (input raw_n, output fault);
    modport user (output raw_n, input fault);
endinterface
`default_nettype wire

// ---- logic/hses_oc_filter.sv ----
// per-port noise filter for the active-low overcurrent inputs
`timescale 1ns/100ps
`default_nettype none
module hses_oc_filter (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // samples in, filtered faults out
    hses_oc_if.filt ocif
);
    // -------------------------------------------------------------------
    // one filter per port: level must hold for the whole window to count
    // -------------------------------------------------------------------
    for (genvar i = 0; i < hses_pkg::NPORTS; i++) begin : g_port
        logic [hses_pkg::OC_CNT_W-1:0] cnt_q;
        logic [hses_pkg::OC_CNT_W-1:0] cnt_d;
        logic flt_q;
        logic flt_d;
        wire logic differs = (~ocif.raw_n[i]) != flt_q;
        wire logic done = differs && (cnt_q == hses_pkg::OC_CNT_LAST);

        // counter restarts whenever the sample agrees with the output
        assign cnt_d = (!differs || done) ? '0 : cnt_q + 1'b1;
        assign flt_d = done ? ~flt_q : flt_q;
        assign ocif.fault[i] = flt_q;

        // filter state
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q <= '0;
                flt_q <= hses_pkg::RST_LOW;
            end else begin
                cnt_q <= cnt_d;
                flt_q <= flt_d;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/hses_board_model.sv ----
// board strap resistors and serial eeprom facing the shared data pin
`timescale 1ns/100ps
`default_nettype none
module hses_board_model (
    // clock
    input wire logic clk,
    // device side of the data pin
    input wire logic data_o,
    input wire logic data_oe_n,
    // strap and memory commands from the bench
    input wire logic eeprom_on,
    input wire logic gang_level,
    input wire logic mem_drive,
    input wire logic mem_level,
    input wire logic mem_slow,
    // resolved data pin level
    output logic data_pin
);
    logic slow_q;
    // a slow memory puts its bit on the pin one clock late
    always_ff @(posedge clk) begin
        slow_q <= mem_level;
    end
    // the clock pin is left unconnected, so nothing loads it
    // strap resistor when off, else device, memory, then pull-down
    assign data_pin = !eeprom_on ? gang_level :
        !data_oe_n ? data_o :
        mem_drive ? (mem_slow ? slow_q : mem_level) : 1'b0;
endmodule
`default_nettype wire

// ---- tb/test_hses_top.sv ----
// self-checking bench for the strap and eeprom pin-select block
`timescale 1ns/100ps
`default_nettype none
module test_hses_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ps = 1'b0, dis = 1'b1, gang = 1'b0, ckl = 1'b0, ckd = 1'b0;
    logic dl = 1'b0, dd = 1'b0, md = 1'b0, ml = 1'b0, ms = 1'b0;
    logic [3:0] oc_n = 4'hf, req = 4'h0, pwr_n, fault;
    logic ck_o, ck_oe_n, d_o, d_oe_n, pin, ee_in, cfg_v, bus_pw, ee_en, gm;
    int err_total = 0;
    int cmp_count = 0;
    int n;
    // clock at 125 MHz
    always #4 clk = ~clk;
    hses_top hses_top_inst (.clk(clk), .rst_n(rst_n),
        .power_source_strap(ps), .eeprom_disable_strap(dis),
        .eeprom_serial_clock_o(ck_o), .eeprom_serial_clock_oe_n(ck_oe_n),
        .eeprom_data_or_gang_strap_i(pin),
        .eeprom_data_or_gang_strap_o(d_o),
        .eeprom_data_or_gang_strap_oe_n(d_oe_n),
        .port_overcurrent_n(oc_n), .port_power_enable_n(pwr_n),
        .ee_clk_level(ckl), .ee_clk_drive(ckd), .ee_data_level(dl),
        .ee_data_drive(dd), .ee_data_in(ee_in), .port_power_req(req),
        .port_fault(fault), .cfg_valid(cfg_v), .bus_powered(bus_pw),
        .eeprom_enabled(ee_en), .gang_mode(gm));
    hses_board_model hses_board_model_inst (.clk(clk), .data_o(d_o),
        .data_oe_n(d_oe_n), .eeprom_on(!dis), .gang_level(gang),
        .mem_drive(md), .mem_level(ml), .mem_slow(ms), .data_pin(pin));
    // step k edges, then settle past the driving delay
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // reset with given straps and wait for the captured configuration
    task automatic restart(input logic p, input logic d, input logic g);
        rst_n = 1'b0;
        ps = p;
        dis = d;
        gang = g;
        oc_n = 4'hf;
        req = 4'hf;
        tick(2);
        check({ck_oe_n, d_oe_n, cfg_v, ee_in, pwr_n}, 8'hcf);
        rst_n = 1'b1;
        n = 0;
        while (cfg_v !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        if (n >= 20) begin
            err_total++;
            complete_run();
        end
        check(n, 8'(hses_pkg::STRAP_SETTLE_CYCLES + 1));
        req = 4'h0;
    endtask
    // every strap combination, then straps moved while running
    task automatic straps_all;
        logic [2:0] k;
        logic [2:0] exp_cfg;
        logic [2:0] exp_pin;
        ckd = 1'b1;
        ckl = 1'b1;
        dd = 1'b1;
        dl = 1'b1;
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            exp_cfg = {k[0], !k[1], k[1] & k[2]};
            exp_pin = {k[1], k[1], !k[1]};
            restart(k[0], k[1], k[2]);
            tick(1);
            check({bus_pw, ee_en, gm}, exp_cfg);
            check({ck_oe_n, d_oe_n, ck_o}, exp_pin);
            ps = !k[0];
            gang = !k[2];
            tick(8);
            check({bus_pw, ee_en, gm}, exp_cfg);
        end
        ckd = 1'b0;
        dd = 1'b0;
    endtask
    // clock toggling, memory reads prompt and slow, device write
    task automatic eeprom_io;
        restart(1'b1, 1'b0, 1'b0);
        ckd = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ckl = i[0];
            tick(1);
            check({ck_oe_n, ck_o}, {1'b0, i[0]});
        end
        md = 1'b1;
        ml = 1'b1;
        tick(5);
        check(ee_in, 8'h01);
        ml = 1'b0;
        tick(5);
        check(ee_in, 8'h00);
        ms = 1'b1;
        ml = 1'b1;
        tick(6);
        check(ee_in, 8'h01);
        md = 1'b0;
        tick(5);
        check(ee_in, 8'h00);
        dd = 1'b1;
        dl = 1'b1;
        tick(1);
        check({d_oe_n, d_o}, 8'h01);
        dd = 1'b0;
        ckd = 1'b0;
    endtask
    // per-port power, a glitch ignored, then a real trip on port 0
    task automatic per_port;
        restart(1'b0, 1'b1, 1'b0);
        req = 4'h5;
        tick(1);
        check(pwr_n, 8'h0a);
        oc_n = 4'he;
        tick(60);
        oc_n = 4'hf;
        tick(130);
        check(fault, 8'h00);
        oc_n = 4'he;
        n = 0;
        while (fault === 4'h0 && n < 200) begin
            tick(1);
            n++;
        end
        check(n >= 120 && n <= 135, 8'h01);
        check({fault, pwr_n}, 8'h1b);
        oc_n = 4'hf;
        req = 4'h4;
        tick(140);
        req = 4'h5;
        tick(2);
        check({fault, pwr_n}, 8'h0a);
    endtask
    // ganged power follows port 0 and one fault trips all
    task automatic ganged;
        restart(1'b0, 1'b1, 1'b1);
        req = 4'h1;
        tick(1);
        check(pwr_n, 8'h00);
        oc_n = 4'hb;
        tick(135);
        check({fault, pwr_n}, 8'hff);
        oc_n = 4'hf;
    endtask
    initial begin
        tick(12);
        rst_n = 1'b1;
        tick(1);
        straps_all();
        eeprom_io();
        per_port();
        ganged();
        complete_run();
    end
endmodule
`default_nettype wire
